// File: verilog/freefall_motion_detect.sv
// Freefall/motion event logic with debounce and source register
//
// Function
// [R1] Config bit 6 picks freefall or motion
// [R2] All axis enables zero disables the detector
// [R3] Latch enable and select give four modes
// [R4] Unlatched freefall sets flag after debounce completes
// [R5] Decrement mode clears flag after debounce delay
// [R6] Clear mode: flag drops when freefall ends
// [R7] Unlatched freefall: source read keeps flag
// [R8] Unlatched: axis flags follow raw enabled status
// [R9] Latched freefall: flag holds until source read
// [R10] Latched freefall read clears flag and counter
// [R11] Latched freefall: axis flags freeze on event
// [R12] Unlatched motion clear mode drops flag immediately
// [R13] Unlatched motion: read clears nothing
// [R14] Latched motion: read clears source and counter
// [R15] Latched motion: flags track, then hold
// [R16] Select zero ANDs axes, one ORs them
// [R17] Axis high when magnitude exceeds threshold
// [R18] Low when enabled axes at or below threshold
// [R19] Counter steps once per new sample
`timescale 1ns/10ps
`include "ffmt_defines.svh"

module freefall_motion_detect (
	input wire logic CLK_I,
	input wire logic SYS_RST_I,
	input wire logic [7:0] ADDR_I,
	input wire logic [7:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	input wire ffmt_pkg::accel_sample_s SAMPLE_I,
	output logic [7:0] RDATA_O,
	output logic EVENT_ACTIVE_O
);
	import ffmt_pkg::*;

	logic [7:0] config_reg;
	logic [7:0] config_next;
	logic [7:0] threshold_reg;
	logic [7:0] threshold_next;
	logic [7:0] length_reg;
	logic [7:0] length_next;
	logic [7:0] count_reg;
	logic [7:0] count_next;
	logic event_active_reg;
	logic event_active_next;
	axis_flags_s flags_reg;
	axis_flags_s flags_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;

	logic latch_enable;
	logic or_and_select;
	logic debounce_mode;
	logic [2:0] axis_enable;
	logic [2:0] axis_high;
	logic [2:0] axis_negative;
	logic [11:0] threshold_scaled;
	logic detect_condition;
	logic source_read;
	axis_flags_s live_flags;
	accel_t axis_value [3];

	assign latch_enable = config_reg[`CFG_LATCH_ENABLE];
	assign or_and_select = config_reg[`CFG_OR_AND_SELECT];
	assign debounce_mode = threshold_reg[`THS_DEBOUNCE_MODE];
	assign axis_enable = {config_reg[`CFG_Z_ENABLE], config_reg[`CFG_Y_ENABLE], config_reg[`CFG_X_ENABLE]};
	assign threshold_scaled = {1'b0, threshold_reg[`THS_VALUE_MSB:0], {`THS_SCALE_BITS{1'b0}}};
	assign axis_value[0] = SAMPLE_I.x;
	assign axis_value[1] = SAMPLE_I.y;
	assign axis_value[2] = SAMPLE_I.z;
	assign source_read = RD_I && (ADDR_I == `ADDR_SOURCE);

	// Per-axis magnitude compare
	for (genvar i = 0; i < 3; i++)
	begin : g_axis
		logic [11:0] magnitude;
		assign magnitude = axis_value[i][11] ? 12'(~axis_value[i] + 12'sh001) : 12'(axis_value[i]);
		assign axis_high[i] = magnitude > threshold_scaled; // [R17]
		assign axis_negative[i] = axis_value[i][11];
	end

	// Raw per-axis flags, gated by the enables
	always_comb
	begin
		live_flags.x_high_event = axis_high[0] & axis_enable[0]; // [R8]
		live_flags.x_polarity = axis_negative[0] & axis_high[0] & axis_enable[0];
		live_flags.y_high_event = axis_high[1] & axis_enable[1];
		live_flags.y_polarity = axis_negative[1] & axis_high[1] & axis_enable[1];
		live_flags.z_high_event = axis_high[2] & axis_enable[2];
		live_flags.z_polarity = axis_negative[2] & axis_high[2] & axis_enable[2];
	end

	// Combined detection condition
	always_comb
	begin
		if (axis_enable == 3'b000)
			detect_condition = 1'b0; // [R2]
		else if (or_and_select)
			detect_condition = |(axis_high & axis_enable); // [R1] [R16]
		else
			detect_condition = (axis_high & axis_enable) == 3'b000; // [R16] [R18]
	end

	// Register writes and read data
	always_comb
	begin
		config_next = config_reg;
		threshold_next = threshold_reg;
		length_next = length_reg;
		rdata_next = `READ_UNMAPPED;
		if (WR_I)
		begin
			unique case (ADDR_I)
				`ADDR_CONFIG: config_next = WDATA_I & `CFG_WRITE_MASK;
				`ADDR_THRESHOLD: threshold_next = WDATA_I;
				`ADDR_DEBOUNCE_LENGTH: length_next = WDATA_I;
				default: config_next = config_reg;
			endcase
		end
		if (RD_I)
		begin
			unique case (ADDR_I)
				`ADDR_CONFIG: rdata_next = config_reg;
				`ADDR_SOURCE: rdata_next = {event_active_reg, 1'b0, flags_reg};
				`ADDR_THRESHOLD: rdata_next = threshold_reg;
				`ADDR_DEBOUNCE_LENGTH: rdata_next = length_reg;
				default: rdata_next = `READ_UNMAPPED;
			endcase
		end
	end

	// Debounce counter, event flag and axis flags
	always_comb
	begin
		count_next = count_reg;
		event_active_next = event_active_reg;
		flags_next = flags_reg;
		// Read clear first so a same-cycle sample can still set
		if (source_read && latch_enable) // [R7] [R13]
		begin
			event_active_next = 1'b0; // [R10] [R14]
			count_next = 8'h00;
			flags_next = '0;
		end
		if (SAMPLE_I.valid)
		begin
			if (detect_condition)
			begin
				if (count_next < length_reg)
					count_next = count_next + 8'h01; // [R19]
			end
			else if (debounce_mode)
				count_next = 8'h00; // [R6] [R12]
			else if (count_next != 8'h00)
				count_next = count_next - 8'h01; // [R5]
			if (latch_enable)
			begin
				// Flags follow raw status until the event latches, then hold
				if (!event_active_next)
				begin
					flags_next = live_flags; // [R11] [R15]
					if (detect_condition && count_next >= length_reg)
						event_active_next = 1'b1; // [R3] [R9]
				end
			end
			else
			begin
				flags_next = live_flags; // [R8]
				if (detect_condition && count_next >= length_reg)
					event_active_next = 1'b1; // [R4]
				else if (!detect_condition && count_next == 8'h00)
					event_active_next = 1'b0; // [R5] [R6] [R12]
			end
		end
		if (axis_enable == 3'b000)
		begin
			count_next = 8'h00; // [R2]
			event_active_next = 1'b0;
		end
	end

	always_ff @(posedge CLK_I)
	begin
		if (SYS_RST_I)
		begin
			config_reg <= `CONFIG_RESET;
			threshold_reg <= `THRESHOLD_RESET;
			length_reg <= `DEBOUNCE_LENGTH_RESET;
			count_reg <= 8'h00;
			event_active_reg <= 1'b0;
			flags_reg <= '0;
			rdata_reg <= `READ_UNMAPPED;
		end
		else
		begin
			config_reg <= config_next;
			threshold_reg <= threshold_next;
			length_reg <= length_next;
			count_reg <= count_next;
			event_active_reg <= event_active_next;
			flags_reg <= flags_next;
			rdata_reg <= rdata_next;
		end
	end

	assign RDATA_O = rdata_reg;
	assign EVENT_ACTIVE_O = event_active_reg;

	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (SYS_RST_I);

	// Detector off forces the event low
	disabled_clear_a: assert property ( // [R2]
		(axis_enable == 3'b000) |=> !event_active_reg
	) else $error("event active while detector disabled");

	// Unlatched freefall read keeps flag and counter
	ff_read_keeps_a: assert property ( // [R7]
		source_read && !latch_enable && !or_and_select && !SAMPLE_I.valid && !WR_I && !SYS_RST_I
		&& axis_enable != 3'b000
		|=> $stable(event_active_reg) && $stable(count_reg)
	) else $error("unlatched freefall read changed state");

	// Unlatched motion read keeps flag and counter
	mt_read_keeps_a: assert property ( // [R13]
		source_read && !latch_enable && or_and_select && !SAMPLE_I.valid && !WR_I && !SYS_RST_I
		&& axis_enable != 3'b000
		|=> $stable(event_active_reg) && $stable(count_reg) && $stable(flags_reg)
	) else $error("unlatched motion read changed state");

	// Latched read clears source and counter
	latch_read_clear_a: assert property ( // [R10] [R14]
		source_read && latch_enable && !SAMPLE_I.valid
		|=> !event_active_reg && count_reg == 8'h00 && flags_reg == '0
	) else $error("latched read did not clear");

	// Latched event holds until read
	latch_hold_a: assert property ( // [R9]
		latch_enable && event_active_reg && !source_read && !WR_I && axis_enable != 3'b000 && !SYS_RST_I
		|=> event_active_reg
	) else $error("latched event dropped without read");

	// Latched flags frozen while event set
	flags_freeze_a: assert property ( // [R11] [R15]
		latch_enable && event_active_reg && !source_read && !WR_I && !SYS_RST_I
		|=> $stable(flags_reg)
	) else $error("axis flags moved while latched");

	// Event only rises on a sample with counter at length
	set_debounce_a: assert property ( // [R4] [R19]
		$rose(event_active_reg) && !$past(WR_I)
		|-> $past(SAMPLE_I.valid) && count_reg >= length_reg
	) else $error("event set without completed debounce");

	// Clear mode drops event and counter at once
	clear_mode_a: assert property ( // [R6] [R12]
		SAMPLE_I.valid && !latch_enable && debounce_mode && !detect_condition && !WR_I
		|=> !event_active_reg && count_reg == 8'h00
	) else $error("clear mode did not clear");

	// Decrement mode steps down and keeps event
	decrement_a: assert property ( // [R5]
		SAMPLE_I.valid && !latch_enable && !debounce_mode && !detect_condition && !WR_I
		&& count_reg > 8'h01 && axis_enable != 3'b000 && !SYS_RST_I
		|=> count_reg == $past(count_reg) - 8'h01 && event_active_reg == $past(event_active_reg)
	) else $error("decrement mode misbehaved");

	// Unlatched flags follow raw status
	live_flags_a: assert property ( // [R8]
		SAMPLE_I.valid && !latch_enable && !WR_I && !SYS_RST_I
		|=> flags_reg == $past(live_flags)
	) else $error("axis flags do not follow samples");

	// Motion with no debounce sets on a high axis
	motion_set_a: assert property ( // [R16] [R17]
		SAMPLE_I.valid && !latch_enable && or_and_select && (axis_high & axis_enable) != 3'b000
		&& length_reg == 8'h00 && !WR_I && !SYS_RST_I
		|=> event_active_reg
	) else $error("motion event not set");

	// Freefall with no debounce sets when enabled axes are low
	freefall_set_a: assert property ( // [R16] [R18]
		SAMPLE_I.valid && !latch_enable && !or_and_select && axis_enable != 3'b000
		&& (axis_high & axis_enable) == 3'b000 && length_reg == 8'h00 && !WR_I && !SYS_RST_I
		|=> event_active_reg
	) else $error("freefall event not set");

	// Latched flags follow samples while no event is held
	flags_track_a: assert property ( // [R15]
		SAMPLE_I.valid && latch_enable && !event_active_reg && !source_read && !WR_I && !SYS_RST_I
		|=> flags_reg == $past(live_flags)
	) else $error("latched axis flags did not track");

	// Disabled detector holds the counter at zero
	disabled_count_a: assert property ( // [R2]
		axis_enable == 3'b000 && !SYS_RST_I
		|=> count_reg == 8'h00
	) else $error("counter moved while detector disabled");

	// Decrement mode clears the event on its last step
	decrement_end_a: assert property ( // [R5]
		SAMPLE_I.valid && !latch_enable && !debounce_mode && !detect_condition && !WR_I
		&& count_reg == 8'h01 && axis_enable != 3'b000 && !SYS_RST_I
		|=> !event_active_reg && count_reg == 8'h00
	) else $error("decrement mode did not clear at zero");

	// Source read returns the event and axis flags
	source_data_a: assert property ( // [R8] [R11]
		source_read && !SYS_RST_I
		|=> RDATA_O == {$past(event_active_reg), 1'b0, $past(flags_reg)}
	) else $error("source read returned wrong data");

endmodule : freefall_motion_detect

// File: verilog/ffmt_defines.svh
// Offsets, field positions, reset values and widths for the freefall/motion detector
`ifndef FFMT_DEFINES_SVH
`define FFMT_DEFINES_SVH

// Register offsets
`define ADDR_CONFIG 8'h15
`define ADDR_SOURCE 8'h16
`define ADDR_THRESHOLD 8'h17
`define ADDR_DEBOUNCE_LENGTH 8'h18

// Config register fields
`define CFG_LATCH_ENABLE 7
`define CFG_OR_AND_SELECT 6
`define CFG_Z_ENABLE 5
`define CFG_Y_ENABLE 4
`define CFG_X_ENABLE 3
`define CFG_WRITE_MASK 8'hf8

// Threshold register fields
`define THS_DEBOUNCE_MODE 7
`define THS_VALUE_MSB 6

// Source register fields
`define SRC_EVENT_ACTIVE 7

// Reset values
`define CONFIG_RESET 8'h00
`define THRESHOLD_RESET 8'h00
`define DEBOUNCE_LENGTH_RESET 8'h00
`define READ_UNMAPPED 8'h00

// Threshold value is shifted left by this many bits before it is compared against the magnitude
`define THS_SCALE_BITS 4

`endif

// File: verilog/ffmt_pkg.sv
// Types shared by the freefall/motion detector
package ffmt_pkg;

	typedef logic signed [11:0] accel_t;

	typedef struct packed {
		logic valid;
		accel_t x;
		accel_t y;
		accel_t z;
	} accel_sample_s;

	typedef struct packed {
		logic z_high_event;
		logic z_polarity;
		logic y_high_event;
		logic y_polarity;
		logic x_high_event;
		logic x_polarity;
	} axis_flags_s;

endpackage : ffmt_pkg

// File: tb/freefall_motion_detect_tb.sv
// Self-checking bench for the freefall/motion detector
`timescale 1ns/10ps
`include "ffmt_defines.svh"
module freefall_motion_detect_tb;
import ffmt_pkg::*;
typedef struct {logic [7:0] cfg; logic [7:0] len; int x; int y; int z; logic [7:0] src;} row_s;
localparam logic [7:0] a_cfg = `ADDR_CONFIG;
localparam logic [7:0] a_src = `ADDR_SOURCE;
localparam logic [7:0] a_ths = `ADDR_THRESHOLD;
localparam logic [7:0] a_len = `ADDR_DEBOUNCE_LENGTH;
logic clk, rst, wstb, rstb, ea;
logic [7:0] addr, wdata, rdata;
accel_sample_s samp;
int errors, total_checks;
row_s rows [8] = '{
	'{8'h48, 8'h00, -1000, 0, 0, 8'h83},
	'{8'h48, 8'h00, 256, 0, 0, 8'h00},
	'{8'h48, 8'h00, 257, 0, 0, 8'h82},
	'{8'h38, 8'h00, 10, -10, 10, 8'h80},
	'{8'h38, 8'h00, 10, -2000, 10, 8'h0c},
	'{8'h40, 8'h00, 1000, 1000, 1000, 8'h00},
	'{8'h70, 8'h00, -1000, 0, 2000, 8'ha0},
	'{8'hd0, 8'h01, 0, -300, 0, 8'h8c}};

freefall_motion_detect u_dut (.CLK_I(clk), .SYS_RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wstb),
	.RD_I(rstb), .SAMPLE_I(samp), .RDATA_O(rdata), .EVENT_ACTIVE_O(ea));

initial
begin
	clk = 0;
	forever #5 clk = ~clk;
end

task chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
	total_checks++;
	if (seen !== exp)
	begin
		errors++;
		$display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
	end
endtask : chk

task chk_ea(input logic exp);
	chk("event_active", {7'h00, ea}, {7'h00, exp});
endtask : chk_ea

task wr(input logic [7:0] a, input logic [7:0] d);
	@(posedge clk);
	addr <= a;
	wdata <= d;
	wstb <= 1'b1;
	@(posedge clk);
	wstb <= 1'b0;
endtask : wr

task rd(input logic [7:0] a, input logic [7:0] exp);
	@(posedge clk);
	addr <= a;
	rstb <= 1'b1;
	@(posedge clk);
	rstb <= 1'b0;
	#1 chk("rdata", rdata, exp);
endtask : rd

task smp(input int x, input int y, input int z);
	@(posedge clk);
	samp <= '{1'b1, accel_t'(x), accel_t'(y), accel_t'(z)};
	@(posedge clk);
	samp.valid <= 1'b0;
	#1;
endtask : smp

task setup(input logic [7:0] ths, input logic [7:0] cfg, input logic [7:0] len);
	@(posedge clk);
	rst <= 1'b1;
	@(posedge clk);
	rst <= 1'b0;
	wr(a_ths, ths);
	wr(a_cfg, cfg);
	wr(a_len, len);
endtask : setup

task wrap_up;
	$display("checks %0d mismatches %0d", total_checks, errors);
	if (errors == 0 && total_checks > 0)
		$display("Simulation passed");
	else
		$display("Simulation failed");
	$finish;
endtask : wrap_up

initial
begin
	repeat (3000) @(posedge clk);
	errors++;
	wrap_up;
end

initial
begin
	rst = 1'b1;
	wstb = 1'b0;
	rstb = 1'b0;
	addr = 8'h00;
	wdata = 8'h00;
	samp = '0;
	errors = 0;
	total_checks = 0;
	repeat (10) @(posedge clk);
	rst <= 1'b0;
	#1 chk_ea(1'b0);
	foreach (rows[i])
	begin
		setup(8'h10, rows[i].cfg, rows[i].len);
		smp(rows[i].x, rows[i].y, rows[i].z);
		chk_ea(rows[i].src[7]);
		rd(a_src, rows[i].src);
		$display("row %0d done", i);
	end
	// Reset values, masks, unmapped and read-only places
	setup(8'h00, 8'h00, 8'h00);
	rd(a_cfg, 8'h00);
	rd(a_ths, 8'h00);
	rd(a_len, 8'h00);
	rd(8'h20, 8'h00);
	wr(a_src, 8'hff);
	rd(a_src, 8'h00);
	wr(a_cfg, 8'hff);
	rd(a_cfg, 8'hf8);
	@(posedge clk);
	#1 chk("rdata idle", rdata, 8'h00);
	$display("registers done");
	// Decrement mode, unlatched motion
	setup(8'h10, 8'h48, 8'h02);
	smp(1000, 0, 0);
	chk_ea(1'b0);
	smp(1000, 0, 0);
	chk_ea(1'b1);
	smp(10, 0, 0);
	chk_ea(1'b1);
	rd(a_src, 8'h80);
	chk_ea(1'b1);
	smp(10, 0, 0);
	chk_ea(1'b0);
	// Clear mode, unlatched motion
	wr(a_ths, 8'h90);
	smp(1000, 0, 0);
	smp(1000, 0, 0);
	chk_ea(1'b1);
	smp(10, 0, 0);
	chk_ea(1'b0);
	// Clear mode, unlatched freefall
	wr(a_cfg, 8'h38);
	smp(10, 10, 10);
	smp(10, 10, 10);
	chk_ea(1'b1);
	rd(a_src, 8'h80);
	chk_ea(1'b1);
	smp(10, 1000, 10);
	chk_ea(1'b0);
	smp(10, 10, 10);
	chk_ea(1'b0);
	smp(10, 10, 10);
	chk_ea(1'b1);
	$display("unlatched done");
	// Latched freefall: hold, freeze, clear on read
	setup(8'h10, 8'h88, 8'h02);
	smp(10, 0, 0);
	smp(10, 0, 0);
	smp(1000, 0, 0);
	chk_ea(1'b1);
	rd(a_src, 8'h80);
	chk_ea(1'b0);
	rd(a_src, 8'h00);
	smp(10, 0, 0);
	chk_ea(1'b0);
	smp(10, 0, 0);
	chk_ea(1'b1);
	// Latched motion: flags hold until read
	setup(8'h10, 8'hc8, 8'h00);
	smp(-1000, 0, 0);
	smp(1000, 0, 0);
	chk_ea(1'b1);
	rd(a_src, 8'h83);
	rd(a_src, 8'h00);
	$display("latched done");
	// Mid-run reset drops a latched event
	smp(-1000, 0, 0);
	chk_ea(1'b1);
	setup(8'h10, 8'hc8, 8'h00);
	#1 chk_ea(1'b0);
	rd(a_src, 8'h00);
	$display("reset done");
	wrap_up;
end
endmodule : freefall_motion_detect_tb
